// ==== scm_defines.svh ====
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH
`define SCM_XLEN 64
`define SCM_WORD 32
`define SCM_OFFW 16
`define SCM_ALIGN_BITS 2
`define SCM_BLOCK_LSB 4
`define SCM_REGION_BYTES 2048
`define SCM_MON_TIMEOUT 8'hff
`endif

// ==== scm_pkg.sv ====
package scm_pkg;
  typedef enum {
    SCM_IDLE,
    SCM_WAIT_MON
  } scm_state_t;
  typedef enum logic [2:0] {
    SCM_EXC_NONE,
    SCM_EXC_TLB_REFILL,
    SCM_EXC_TLB_INVALID,
    SCM_EXC_TLB_MODIFIED,
    SCM_EXC_ADDR_ERROR,
    SCM_EXC_WATCH
  } scm_exc_t;
endpackage

// ==== scm_addr_gen.sv ====
`include "scm_defines.svh"
module scm_addr_gen (
  input wire logic [`SCM_XLEN-1:0] base_val,
  input wire logic [`SCM_OFFW-1:0] offset,
  output logic [`SCM_XLEN-1:0] eff_addr,
  output logic misaligned
);
  always_comb begin
    eff_addr = base_val + {{(`SCM_XLEN-`SCM_OFFW){offset[`SCM_OFFW-1]}}, offset};
    misaligned = |eff_addr[`SCM_ALIGN_BITS-1:0];
  end
endmodule // scm_addr_gen

// ==== scm_link_track.sv ====
`include "scm_defines.svh"
module scm_link_track (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic set_link,
  input wire logic [`SCM_XLEN-1:0] set_addr,
  input wire logic set_uncached,
  input wire logic kill,
  output logic link_valid,
  output logic [`SCM_XLEN-1:0] link_addr,
  output logic link_uncached
);
  logic next_valid;
  logic [`SCM_XLEN-1:0] next_addr;
  logic next_unc;
  always_comb begin
    next_valid = link_valid;
    next_addr = link_addr;
    next_unc = link_uncached;
    if (kill) begin
      next_valid = 1'b0;
    end
    if (set_link) begin
      next_valid = 1'b1;
      next_addr = {set_addr[`SCM_XLEN-1:`SCM_ALIGN_BITS], `SCM_ALIGN_BITS'(0)};
      next_unc = set_uncached;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link_valid <= 1'b0;
      link_addr <= '0;
      link_uncached <= 1'b0;
    end else if (clk_en) begin
      link_valid <= next_valid;
      link_addr <= next_addr;
      link_uncached <= next_unc;
    end
  end
endmodule // scm_link_track

// ==== scm_store_cond.sv ====
// Overview of operation
// RL1: Success stores low 32 bits at aligned address
// RL2: Success writes one into target register
// RL3: Failure skips memory, writes zero to register
// RL4: Address is base plus sign-extended offset
// RL5: Remote coherent store to block fails
// RL6: Own coherent store fails when link mode set
// RL7: Exception return fails; keep-link variant does not
// RL8: Aligned address mismatch with linked load fails
// RL9: Own load keeps link when link mode set
// RL10: Unrelated accesses or far fetch may fail
// RL11: Cache maintenance may fail; mandatory in link mode
// RL12: Unpaired store still gives defined outcome
// RL13: Uncached: fail locally or ask external monitor
// RL14: External monitor decides uncached final outcome
// RL15: Own uncached store to reserved address fails
// RL16: Monitor may fail on remote uncached stores
// RL17: Non-synchronizable uncached sequence gets bus error
// RL18: Pause after uncached linked load is no-op
// RL19: Accelerated uncached store closes gathering, never joins
// RL20: Low two address bits nonzero raise address error
// RL21: Only translation, address and watch exceptions
// RL22: One link flag and address, cleared on consume
`include "scm_defines.svh"
module scm_store_cond (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic link_bit_mode,
  input wire logic uncached_link_support,
  input wire logic ll_valid,
  input wire logic ll_uncached,
  input wire logic sc_valid,
  input wire logic sc_uncached,
  input wire logic sc_accel,
  input wire logic [`SCM_XLEN-1:0] base_val,
  input wire logic [`SCM_OFFW-1:0] offset,
  input wire logic [`SCM_XLEN-1:0] source_target_reg,
  input wire logic [4:0] target_idx,
  input wire logic tlb_refill,
  input wire logic tlb_invalid,
  input wire logic tlb_modified,
  input wire logic watch_hit,
  input wire logic remote_coh_store,
  input wire logic [`SCM_XLEN-1:0] remote_store_addr,
  input wire logic own_coh_store,
  input wire logic own_unc_store,
  input wire logic own_load,
  input wire logic [`SCM_XLEN-1:0] own_access_addr,
  input wire logic own_other_access,
  input wire logic cache_op,
  input wire logic exception_return,
  input wire logic exception_return_keep_link,
  input wire logic fetch_region_break,
  input wire logic pause_issue,
  input wire logic mon_ready,
  input wire logic mon_resp_valid,
  input wire logic mon_resp_ok,
  input wire logic mon_bus_error,
  output logic mem_wr_valid,
  output logic [`SCM_XLEN-1:0] mem_wr_addr,
  output logic [`SCM_WORD-1:0] mem_wr_data,
  output logic mem_no_gather,
  output logic gather_flush,
  output logic mon_req_valid,
  output logic [`SCM_XLEN-1:0] mon_req_addr,
  output logic [`SCM_WORD-1:0] mon_req_data,
  output logic gr_wr_valid,
  output logic [4:0] gr_wr_idx,
  output logic [`SCM_XLEN-1:0] gr_wr_data,
  output logic exc_valid,
  output scm_pkg::scm_exc_t exc_code,
  output logic pause_nop,
  output logic busy
);
  function automatic logic same_block(input logic [`SCM_XLEN-1:0] a,
                                      input logic [`SCM_XLEN-1:0] b);
    same_block = a[`SCM_XLEN-1:`SCM_BLOCK_LSB] == b[`SCM_XLEN-1:`SCM_BLOCK_LSB];
  endfunction

  logic [`SCM_XLEN-1:0] eff_addr;
  logic misaligned;
  logic link_valid;
  logic [`SCM_XLEN-1:0] link_addr;
  logic link_uncached;
  logic kill;
  logic consume;

  scm_addr_gen u_addr (
    .base_val(base_val),
    .offset(offset),
    .eff_addr(eff_addr), // [RL4]
    .misaligned(misaligned)
  );

  // Any event that breaks the reservation
  always_comb begin
    kill = 1'b0;
    if (remote_coh_store && same_block(remote_store_addr, link_addr)) begin
      kill = 1'b1; // [RL5]
    end
    if (own_coh_store && same_block(own_access_addr, link_addr) && !link_uncached) begin
      kill = 1'b1; // [RL6]
    end
    if (own_unc_store && link_uncached &&
        own_access_addr[`SCM_XLEN-1:`SCM_ALIGN_BITS] ==
        link_addr[`SCM_XLEN-1:`SCM_ALIGN_BITS]) begin
      kill = 1'b1; // [RL15]
    end
    if (exception_return && !exception_return_keep_link) begin
      kill = 1'b1; // [RL7]
    end
    if (own_load && !link_bit_mode && same_block(own_access_addr, link_addr)) begin
      kill = 1'b1; // [RL9]
    end
    if (own_other_access || fetch_region_break) begin
      kill = 1'b1; // [RL10]
    end
    if (cache_op) begin
      kill = 1'b1; // [RL11]
    end
    if (consume) begin
      kill = 1'b1; // [RL22]
    end
  end

  scm_link_track u_link (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .set_link(ll_valid), // [RL22]
    .set_addr(eff_addr),
    .set_uncached(ll_uncached && uncached_link_support),
    .kill(kill),
    .link_valid(link_valid),
    .link_addr(link_addr),
    .link_uncached(link_uncached)
  );

  scm_pkg::scm_state_t state, next_state;
  logic [4:0] hold_idx, next_hold_idx;
  logic [7:0] wait_cnt, next_wait_cnt;
  logic next_mem_wr_valid, next_mem_no_gather, next_gather_flush;
  logic [`SCM_XLEN-1:0] next_mem_wr_addr, next_mon_req_addr, next_gr_wr_data;
  logic [`SCM_WORD-1:0] next_mem_wr_data, next_mon_req_data;
  logic next_mon_req_valid, next_gr_wr_valid, next_exc_valid, next_pause_nop;
  logic [4:0] next_gr_wr_idx;
  scm_pkg::scm_exc_t next_exc_code;
  logic local_ok;
  logic [`SCM_XLEN-1:0] aligned_addr;

  always_comb begin
    aligned_addr = {eff_addr[`SCM_XLEN-1:`SCM_ALIGN_BITS], `SCM_ALIGN_BITS'(0)};
    local_ok = link_valid && !kill_pending(aligned_addr) &&
               aligned_addr == link_addr; // [RL8]
    next_state = state;
    next_hold_idx = hold_idx;
    next_wait_cnt = wait_cnt;
    next_mem_wr_valid = 1'b0;
    next_mem_wr_addr = mem_wr_addr;
    next_mem_wr_data = mem_wr_data;
    next_mem_no_gather = 1'b0;
    next_gather_flush = 1'b0;
    next_mon_req_valid = mon_req_valid;
    next_mon_req_addr = mon_req_addr;
    next_mon_req_data = mon_req_data;
    next_gr_wr_valid = 1'b0;
    next_gr_wr_idx = gr_wr_idx;
    next_gr_wr_data = gr_wr_data;
    next_exc_valid = 1'b0;
    next_exc_code = scm_pkg::SCM_EXC_NONE;
    next_pause_nop = pause_issue && link_valid && link_uncached; // [RL18]
    consume = 1'b0;
    case (state)
      scm_pkg::SCM_IDLE: begin
        if (sc_valid) begin
          consume = 1'b1; // [RL22]
          if (misaligned || tlb_refill || tlb_invalid || tlb_modified || watch_hit) begin
            next_exc_valid = 1'b1; // [RL21]
            if (misaligned) begin
              next_exc_code = scm_pkg::SCM_EXC_ADDR_ERROR; // [RL20]
            end else if (tlb_refill) begin
              next_exc_code = scm_pkg::SCM_EXC_TLB_REFILL;
            end else if (tlb_invalid) begin
              next_exc_code = scm_pkg::SCM_EXC_TLB_INVALID;
            end else if (tlb_modified) begin
              next_exc_code = scm_pkg::SCM_EXC_TLB_MODIFIED;
            end else begin
              next_exc_code = scm_pkg::SCM_EXC_WATCH;
            end
          end else if (sc_uncached && uncached_link_support && local_ok && link_uncached) begin
            next_mon_req_valid = 1'b1; // [RL13]
            next_mon_req_addr = aligned_addr;
            next_mon_req_data = source_target_reg[`SCM_WORD-1:0];
            next_gather_flush = sc_accel; // [RL19]
            next_mem_no_gather = 1'b1; // [RL19]
            next_hold_idx = target_idx;
            next_wait_cnt = 8'h00;
            next_state = scm_pkg::SCM_WAIT_MON;
          end else if (local_ok && !sc_uncached && !link_uncached) begin
            next_mem_wr_valid = 1'b1; // [RL1]
            next_mem_wr_addr = aligned_addr;
            next_mem_wr_data = source_target_reg[`SCM_WORD-1:0];
            next_gr_wr_valid = 1'b1; // [RL2]
            next_gr_wr_idx = target_idx;
            next_gr_wr_data = `SCM_XLEN'(1);
          end else begin
            next_gr_wr_valid = 1'b1; // [RL3] [RL12]
            next_gr_wr_idx = target_idx;
            next_gr_wr_data = '0;
          end
        end
      end
      scm_pkg::SCM_WAIT_MON: begin
        next_mem_no_gather = 1'b1; // [RL19]
        if (mon_req_valid && mon_ready) begin
          next_mon_req_valid = 1'b0;
        end
        next_wait_cnt = wait_cnt + 8'h01;
        if (mon_resp_valid) begin
          next_state = scm_pkg::SCM_IDLE;
          next_mon_req_valid = 1'b0;
          next_gr_wr_valid = 1'b1; // [RL14]
          next_gr_wr_idx = hold_idx;
          next_gr_wr_data = `SCM_XLEN'(mon_resp_ok && !mon_bus_error); // [RL17]
        end else if (wait_cnt == `SCM_MON_TIMEOUT) begin
          next_state = scm_pkg::SCM_IDLE;
          next_mon_req_valid = 1'b0;
          next_gr_wr_valid = 1'b1; // [RL16]
          next_gr_wr_idx = hold_idx;
          next_gr_wr_data = '0;
        end
      end
      default: begin
        next_state = scm_pkg::SCM_IDLE;
      end
    endcase
  end

  // Same-cycle remote coherent store, exception return or cache op also defeats the store
  function automatic logic kill_pending(input logic [`SCM_XLEN-1:0] a);
    kill_pending = (remote_coh_store && same_block(remote_store_addr, a)) ||
                   (exception_return && !exception_return_keep_link) || cache_op;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= scm_pkg::SCM_IDLE;
      hold_idx <= '0;
      wait_cnt <= '0;
      mem_wr_valid <= 1'b0;
      mem_wr_addr <= '0;
      mem_wr_data <= '0;
      mem_no_gather <= 1'b0;
      gather_flush <= 1'b0;
      mon_req_valid <= 1'b0;
      mon_req_addr <= '0;
      mon_req_data <= '0;
      gr_wr_valid <= 1'b0;
      gr_wr_idx <= '0;
      gr_wr_data <= '0;
      exc_valid <= 1'b0;
      exc_code <= scm_pkg::SCM_EXC_NONE;
      pause_nop <= 1'b0;
      busy <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      hold_idx <= next_hold_idx;
      wait_cnt <= next_wait_cnt;
      mem_wr_valid <= next_mem_wr_valid;
      mem_wr_addr <= next_mem_wr_addr;
      mem_wr_data <= next_mem_wr_data;
      mem_no_gather <= next_mem_no_gather;
      gather_flush <= next_gather_flush;
      mon_req_valid <= next_mon_req_valid;
      mon_req_addr <= next_mon_req_addr;
      mon_req_data <= next_mon_req_data;
      gr_wr_valid <= next_gr_wr_valid;
      gr_wr_idx <= next_gr_wr_idx;
      gr_wr_data <= next_gr_wr_data;
      exc_valid <= next_exc_valid;
      exc_code <= next_exc_code;
      pause_nop <= next_pause_nop;
      busy <= next_state == scm_pkg::SCM_WAIT_MON;
    end
  end
endmodule // scm_store_cond

// ==== scm_store_cond_asserts.sv ====
module scm_store_cond_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic sc_valid,
  input wire logic sc_uncached,
  input wire logic sc_accel,
  input wire logic [63:0] base_val,
  input wire logic [15:0] offset,
  input wire logic [63:0] source_target_reg,
  input wire logic mon_ready,
  input wire logic mon_resp_valid,
  input wire logic mon_resp_ok,
  input wire logic mon_bus_error,
  input wire logic busy,
  input wire logic mem_wr_valid,
  input wire logic [63:0] mem_wr_addr,
  input wire logic [31:0] mem_wr_data,
  input wire logic mon_req_valid,
  input wire logic [63:0] mon_req_addr,
  input wire logic gr_wr_valid,
  input wire logic [63:0] gr_wr_data,
  input wire logic exc_valid,
  input wire scm_pkg::scm_exc_t exc_code,
  input wire logic mem_no_gather,
  input wire logic gather_flush
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic [63:0] ea;
  assign ea = base_val + {{48{offset[15]}}, offset};
  sequence s_take;
    clk_en && sc_valid && !busy;
  endsequence
  sequence s_take_cached;
    s_take ##0 !sc_uncached;
  endsequence
  property p_succ_one;
    mem_wr_valid |-> gr_wr_valid && gr_wr_data == 64'h1;
  endproperty
  a_succ_one: assert property (p_succ_one) else $error("write without one");
  property p_wr_aligned;
    mem_wr_valid |-> mem_wr_addr[1:0] == 2'h0;
  endproperty
  a_wr_aligned: assert property (p_wr_aligned) else $error("unaligned write");
  property p_wr_data;
    s_take_cached ##1 mem_wr_valid |-> mem_wr_data == $past(source_target_reg[31:0]);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("bad store data");
  property p_wr_origin;
    mem_wr_valid |-> $past(sc_valid && clk_en);
  endproperty
  a_wr_origin: assert property (p_wr_origin) else $error("write without store");
  property p_misalign;
    s_take ##0 ea[1:0] != 2'h0 |=> exc_valid && exc_code == scm_pkg::SCM_EXC_ADDR_ERROR;
  endproperty
  a_misalign: assert property (p_misalign) else $error("no address error");
  property p_exc_nowr;
    exc_valid |-> !mem_wr_valid && !gr_wr_valid;
  endproperty
  a_exc_nowr: assert property (p_exc_nowr) else $error("write on exception");
  property p_unc_local;
    s_take ##0 sc_uncached |=> !mem_wr_valid && !(gr_wr_valid && gr_wr_data == 64'h1);
  endproperty
  a_unc_local: assert property (p_unc_local) else $error("local success");
  property p_req_hold;
    mon_req_valid && !mon_ready |=> mon_req_valid && $stable(mon_req_addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");
  property p_resp;
    clk_en && busy && mon_resp_valid |=> gr_wr_valid &&
      gr_wr_data == {63'h0, $past(mon_resp_ok && !mon_bus_error)};
  endproperty
  a_resp: assert property (p_resp) else $error("monitor outcome lost");
  property p_flush;
    s_take ##0 sc_uncached && sc_accel ##1 mon_req_valid |-> gather_flush && mem_no_gather;
  endproperty
  a_flush: assert property (p_flush) else $error("gathering not closed");
endmodule // scm_store_cond_asserts
bind scm_store_cond scm_store_cond_asserts u_asserts (.*);

// ==== scm_mon_model.sv ====
module scm_mon_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mon_req_valid,
  input wire logic [7:0] delay,
  input wire logic ok,
  input wire logic bus_err,
  output logic mon_ready,
  output logic mon_resp_valid,
  output logic mon_resp_ok,
  output logic mon_bus_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act;
  logic [7:0] cnt;
  always_ff @(posedge ref_clk) begin
    mon_ready <= 1'b0;
    mon_resp_valid <= 1'b0;
    mon_resp_ok <= ~mon_resp_ok;
    mon_bus_error <= ~mon_bus_error;
    if (rst) begin
      act <= 1'b0;
      mon_resp_ok <= 1'b0;
      mon_bus_error <= 1'b0;
    end else if (mon_req_valid && !act) begin
      act <= 1'b1;
      cnt <= delay;
      mon_ready <= 1'b1;
    end else if (act && cnt != 8'h0) begin
      cnt <= cnt - 8'h1;
    end else if (act) begin
      act <= 1'b0;
      mon_resp_valid <= 1'b1;
      mon_resp_ok <= ok;
      mon_bus_error <= bus_err;
    end
  end
endmodule // scm_mon_model

// ==== scm_store_cond_tb.sv ====
module scm_store_cond_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [65:0] OK = {2'h2, 64'h1};
  localparam logic [65:0] FAIL = 66'h0;
  logic ref_clk, rst, clk_en, link_bit_mode, uncached_link_support, ll_valid, ll_uncached;
  logic sc_valid, sc_uncached, sc_accel, mon_ready, mon_resp_valid, mon_resp_ok, mon_bus_error;
  logic [63:0] base_val, source_target_reg, remote_store_addr, own_access_addr, a;
  logic [63:0] mem_wr_addr, mon_req_addr, gr_wr_data;
  logic [15:0] offset;
  logic [4:0] target_idx, gr_wr_idx;
  logic [31:0] mem_wr_data, mon_req_data;
  logic mem_wr_valid, mem_no_gather, gather_flush, mon_req_valid, gr_wr_valid, exc_valid;
  logic pause_nop, busy, mok, mberr;
  scm_pkg::scm_exc_t exc_code;
  logic [9:0] ev;
  logic [3:0] ex;
  logic [7:0] mdly;
  logic [65:0] e;
  logic [65:0] exp_q[$];
  int miscompares, n_checks, seed;
  scm_store_cond u_dut (.*, .remote_coh_store(ev[0]), .own_coh_store(ev[1]),
    .own_unc_store(ev[2]), .own_load(ev[3]), .own_other_access(ev[4]), .cache_op(ev[5]),
    .exception_return(ev[6]), .exception_return_keep_link(ev[7]),
    .fetch_region_break(ev[8]), .pause_issue(ev[9]), .tlb_refill(ex[0]),
    .tlb_invalid(ex[1]), .tlb_modified(ex[2]), .watch_hit(ex[3]));
  scm_mon_model u_mon (.ref_clk(ref_clk), .rst(rst), .mon_req_valid(mon_req_valid),
    .delay(mdly), .ok(mok), .bus_err(mberr), .mon_ready(mon_ready),
    .mon_resp_valid(mon_resp_valid), .mon_resp_ok(mon_resp_ok), .mon_bus_error(mon_bus_error));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ll(logic [63:0] b, logic u);
    @(negedge ref_clk);
    ll_valid = 1'b1;
    ll_uncached = u;
    base_val = b;
    offset = 16'h0;
    @(negedge ref_clk);
    ll_valid = 1'b0;
  endtask
  task automatic pulse(int k);
    @(negedge ref_clk);
    ev[k] = 1'b1;
    @(negedge ref_clk);
    ev = 10'h0;
  endtask
  // Result note: bit 65 memory write, bit 64 exception, low bits value or code
  task automatic sc(logic [63:0] b, logic [15:0] o, logic u, logic tk, logic [65:0] r);
    @(negedge ref_clk);
    sc_valid = 1'b1;
    sc_uncached = u;
    base_val = b;
    offset = o;
    clk_en = tk;
    source_target_reg = {$random(seed), $random(seed)};
    target_idx = 5'($random(seed));
    if (tk) exp_q.push_back(r);
    @(negedge ref_clk);
    sc_valid = 1'b0;
    ex = 4'h0;
    clk_en = 1'b1;
    for (int i = 0; i < 400 && (busy !== 1'b0 || exp_q.size() != 0); i++) @(negedge ref_clk);
  endtask
  always @(negedge ref_clk) begin
    if (gr_wr_valid === 1'b1 || exc_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("extra", 64'h1, 64'h0);
      else begin
        e = exp_q.pop_front();
        chk("mem_wr", {63'h0, mem_wr_valid}, {63'h0, e[65]});
        if (e[65]) chk("wr_addr", mem_wr_addr, a);
        if (e[65]) chk("wr_data", {32'h0, mem_wr_data}, {32'h0, source_target_reg[31:0]});
        if (!e[64]) chk("gr_idx", {59'h0, gr_wr_idx}, {59'h0, target_idx});
        if (e[64]) chk("exc", {61'h0, exc_code}, e[63:0]);
        else chk("gr", gr_wr_data, e[63:0]);
      end
    end
  end
  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end
  initial begin
    seed = 32'ha371;
    {rst, clk_en, link_bit_mode, uncached_link_support} = 4'hf;
    {ll_valid, ll_uncached, sc_valid, sc_uncached, sc_accel, mberr} = 6'h0;
    {base_val, source_target_reg, offset, target_idx, ev, ex, mdly, mok} = 0;
    miscompares = 0;
    n_checks = 0;
    a = {$random(seed), $random(seed)};
    a[3:0] = 4'h0;
    remote_store_addr = a + 64'h8;
    own_access_addr = a + 64'h4;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    for (int k = 0; k < 9; k++) if (k != 2) begin
      ll(a, 1'b0);
      pulse(k);
      sc(a, 16'h0, 1'b0, 1'b1, (k == 3 || k == 7) ? OK : FAIL);
    end
    link_bit_mode = 1'b0;
    ll(a, 1'b0);
    pulse(3);
    sc(a, 16'h0, 1'b0, 1'b1, FAIL);
    link_bit_mode = 1'b1;
    ll(a, 1'b0);
    sc(a + 64'h100, 16'hff00, 1'b0, 1'b1, OK);
    sc(a, 16'h0, 1'b0, 1'b1, FAIL);
    ll(a, 1'b0);
    sc(a, 16'h4, 1'b0, 1'b1, FAIL);
    ll(a, 1'b0);
    sc(a, 16'h0, 1'b0, 1'b0, FAIL);
    sc(a, 16'h0, 1'b0, 1'b1, OK);
    for (int i = 1; i < 8; i++) begin
      ll(a, 1'b0);
      ex = (i < 4) ? 4'hf : 4'(1 << (i - 4));
      sc(a, 16'(i < 4 ? i : 0), 1'b0, 1'b1, {2'h1, 64'(i < 4 ? 4 : (i == 7 ? 5 : i - 3))});
    end
    for (int i = 0; i < 4; i++) begin
      mdly = 8'(i * 20 + 1);
      mok = (i != 1);
      mberr = (i == 2);
      sc_accel = i[0];
      ll(a, 1'b1);
      pulse(9);
      chk("pause", {63'h0, pause_nop}, 64'h1);
      if (i == 3) begin
        own_access_addr = a;
        pulse(2);
      end
      sc(a, 16'h0, 1'b1, 1'b1, {2'h0, 64'(i == 0)});
    end
    chk("left", 64'(exp_q.size()), 64'h0);
    finish_test();
  end
endmodule // scm_store_cond_tb
